// File: inc/bch_consts.svh
// Constants for the bubble controller host port
`ifndef BCH_CONSTS_SVH
`define BCH_CONSTS_SVH

// Command codes, written with the port select line high
`define BCH_CMD_WBL_MASKED 8'h10
`define BCH_CMD_INIT 8'h11
`define BCH_CMD_RD_BLREG 8'h15
`define BCH_CMD_WR_BLREG 8'h16
`define BCH_CMD_ABORT 8'h19
`define BCH_CMD_FIFO_RST 8'h1d
`define BCH_CMD_PURGE 8'h1e
`define BCH_CMD_SW_RST 8'h1f
`define BCH_CMD_GROUP 4'h1

// Register select codes, low nibble of a select write with high nibble zero
`define BCH_SEL_BLOCK_LEN 4'hb
`define BCH_SEL_CHAN 4'hc
`define BCH_SEL_RATE 4'hd
`define BCH_SEL_ADDR_LO 4'he
`define BCH_SEL_ADDR_HI 4'hf
`define BCH_SEL_GROUP 4'h0

// Status byte bit positions
`define BCH_ST_BUSY 7
`define BCH_ST_OPDONE 6
`define BCH_ST_OPFAIL 5
`define BCH_ST_TIMING 4
`define BCH_ST_PARITY 2
`define BCH_ST_DATA 0

// Parameter encodings decoded onto the mode outputs
`define BCH_BLEN_ONE_PAGE 8'h01
`define BCH_RATE_STD 8'h08
`define BCH_CHAN_TWO_BIT 4

// FIFO and bootloop sizing
`define BCH_FIFO_DEPTH 40
`define BCH_FIFO_AW 6
`define BCH_BL_BYTES 40
`define BCH_BL_AW 6

// Power-up sequence length in cycles, and initialize probe timeout
`define BCH_PWRUP_CYC 16'h0100
`define BCH_INIT_TMO_CYC 16'h0400
`define BCH_CNT_W 16

`endif

// File: inc/bch_pkg.sv
// Types for the bubble controller host port
`default_nettype none
package bch_pkg;
   typedef enum {
      BCH_PWRUP,
      BCH_LOCKED,
      BCH_IDLE,
      BCH_INIT,
      BCH_WR_BL,
      BCH_RD_BL
   } bch_state_type;

   typedef struct packed {
      logic [7:0] block_length;
      logic [7:0] channel_select;
      logic [7:0] transfer_rate_cfg;
      logic [7:0] page_address_low;
      logic [7:0] page_address_high_unit;
   } bch_param_type;

   typedef struct packed {
      logic busy;
      logic op_done;
      logic op_fail;
      logic timing_err;
      logic parity_err;
   } bch_flags_type;
endpackage : bch_pkg
`default_nettype wire

// File: src/bch_fifo.sv
// Byte FIFO with valid/ready on both sides and a synchronous flush
`default_nettype none
`include "bch_consts.svh"
module bch_fifo
   import bch_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 40,
   parameter int AW = 6
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic flush,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [AW:0] level
);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic push, pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : bump

   assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem_reg[rd_reg];
   assign level = cnt_reg;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      wr_next = push ? bump(wr_reg) : wr_reg;
      rd_next = pop ? bump(rd_reg) : rd_reg;
      cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      if (flush)
      begin
         wr_next = '0;
         rd_next = '0;
         cnt_next = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end
      else
      begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
      end
   end

   // Storage has no reset; data is only visible behind the count
   always_ff @(posedge clk)
   begin
      if (push && !flush)
      begin
         mem_reg[wr_reg] <= in_data;
      end
   end
endmodule : bch_fifo
`default_nettype wire

// File: src/bch_host_port.sv
// Host-facing command/status and data port of the bubble controller
//
// Contract
// - Status reads 40h after power-up and parameter load
// - Data port moves FIFO bytes and parameter bytes
// - 40-byte FIFO returns bytes in order
// - Full FIFO status reads 41h
// - Drained FIFO status reads 40h or 42h
// - Abort completion reports 40h
// - Purge clears all but block length and bootloop register
// - Purge completion reports operation complete
// - Initialize probes bubble; no answer flags timing
// - Parameter encodings 01h, 10h, 08h honoured
// - Zero address selects page 0, first device
// - Bootloop register commands move FIFO data
// - After power-up only initialize or abort
// - Command codes 19h, 1eh, 11h decode
// - Parameter load discards first FIFO byte
// - Software reset clears errors, empties FIFO
`default_nettype none
`include "bch_consts.svh"
module bch_host_port
   import bch_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Host bus
   input wire logic cs,
   input wire logic rd_stb,
   input wire logic wr_stb,
   input wire logic port_select_line,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   // Formatter channel presence and parity hint
   input wire logic formatter_sense_amp_ready,
   input wire logic formatter_sense_amp_parity_err,
   // Power-up done, decoded configuration
   output logic pwrup_done,
   output logic one_page_mode,
   output logic two_channel_mode,
   output logic std_rate_mode,
   output logic [11:0] page_address,
   output logic [3:0] module_unit
);
   // ----------------------------------------------------------------
   // Host access decode
   // ----------------------------------------------------------------
   logic cmd_wr, sel_wr, data_wr, data_rd, stat_rd;
   logic [7:0] rd_data_next, rd_data_reg;

   assign cmd_wr = cs && wr_stb && port_select_line
                   && (wr_data[7:4] == `BCH_CMD_GROUP);
   assign sel_wr = cs && wr_stb && port_select_line
                   && (wr_data[7:4] == `BCH_SEL_GROUP);
   assign data_wr = cs && wr_stb && !port_select_line;
   assign data_rd = cs && rd_stb && !port_select_line;
   assign stat_rd = cs && rd_stb && port_select_line;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   bch_state_type state_reg, state_next;
   bch_param_type prm_reg, prm_next;
   bch_flags_type flg_reg, flg_next;
   logic [3:0] sel_reg, sel_next;
   logic [`BCH_CNT_W-1:0] cnt_reg, cnt_next;
   logic [7:0] bl_mem [`BCH_BL_BYTES];
   logic [`BCH_BL_AW-1:0] bl_idx_reg, bl_idx_next;
   logic [1:0] fsa_seen_reg, fsa_seen_next;
   logic [1:0] nfc_reg, nfc_next;
   logic discard_reg, discard_next;

   // ----------------------------------------------------------------
   // FIFO between host and bootloop mover
   // ----------------------------------------------------------------
   logic f_in_valid, f_in_ready, f_out_valid, f_out_ready, f_flush;
   logic [7:0] f_in_data, f_out_data;
   logic [`BCH_FIFO_AW:0] f_level;

   bch_fifo #(
      .WIDTH(8),
      .DEPTH(`BCH_FIFO_DEPTH),
      .AW(`BCH_FIFO_AW)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .flush(f_flush),
      .in_valid(f_in_valid),
      .in_ready(f_in_ready),
      .in_data(f_in_data),
      .out_valid(f_out_valid),
      .out_ready(f_out_ready),
      .out_data(f_out_data),
      .level(f_level)
   );

   // Register select code to parameter slot index
   function automatic logic [2:0] sel_slot(input logic [3:0] s);
      case (s)
         `BCH_SEL_BLOCK_LEN: sel_slot = 3'h0;
         `BCH_SEL_CHAN: sel_slot = 3'h1;
         `BCH_SEL_RATE: sel_slot = 3'h2;
         `BCH_SEL_ADDR_LO: sel_slot = 3'h3;
         `BCH_SEL_ADDR_HI: sel_slot = 3'h4;
         default: sel_slot = 3'h7;
      endcase
   endfunction : sel_slot

   logic idle_ok;
   assign idle_ok = (state_reg == BCH_IDLE) || (state_reg == BCH_LOCKED);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      prm_next = prm_reg;
      flg_next = flg_reg;
      sel_next = sel_reg;
      cnt_next = cnt_reg;
      bl_idx_next = bl_idx_reg;
      fsa_seen_next = fsa_seen_reg;
      nfc_next = nfc_reg;
      discard_next = discard_reg;
      f_flush = 1'b0;
      f_in_valid = 1'b0;
      f_in_data = wr_data;
      f_out_ready = 1'b0;

      // Host data writes fill the FIFO only in the idle and locked states
      if (data_wr && idle_ok)
      begin
         f_in_valid = 1'b1;
      end
      if (data_rd && idle_ok)
      begin
         f_out_ready = 1'b1;
      end

      // Parameter load through the select pointer
      if (sel_wr && idle_ok)
      begin
         sel_next = wr_data[3:0];
         discard_next = 1'b1;
      end
      // A register load costs one FIFO byte per select write, not one
      // per parameter byte, so a full five-byte load loses only the oldest
      if (data_wr && idle_ok && sel_slot(sel_reg) != 3'h7)
      begin
         f_in_valid = 1'b0;
         case (sel_slot(sel_reg))
            3'h0: prm_next.block_length = wr_data;
            3'h1: prm_next.channel_select = wr_data;
            3'h2: prm_next.transfer_rate_cfg = wr_data;
            3'h3: prm_next.page_address_low = wr_data;
            default: prm_next.page_address_high_unit = wr_data;
         endcase
         sel_next = (sel_reg == `BCH_SEL_ADDR_HI) ? 4'h0 : sel_reg + 4'h1;
      end
      // Loading parameters destroys the oldest FIFO byte
      if (discard_reg && f_out_valid && !f_out_ready)
      begin
         f_out_ready = 1'b1;
         discard_next = 1'b0;
      end
      else if (discard_reg && !f_out_valid)
      begin
         discard_next = 1'b0;
      end

      case (state_reg)
         BCH_PWRUP:
         begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == `BCH_PWRUP_CYC)
            begin
               state_next = BCH_LOCKED;
               flg_next = '0;
               flg_next.op_done = 1'b1;
               f_flush = 1'b1;
            end
         end
         BCH_LOCKED:
         begin
            if (cmd_wr && wr_data == `BCH_CMD_ABORT)
            begin
               flg_next = '0;
               flg_next.op_done = 1'b1;
               state_next = BCH_IDLE;
            end
            else if (cmd_wr && wr_data == `BCH_CMD_INIT)
            begin
               flg_next = '0;
               flg_next.busy = 1'b1;
               cnt_next = '0;
               state_next = BCH_INIT;
            end
         end
         BCH_IDLE:
         begin
            if (cmd_wr)
            begin
               flg_next = '0;
               case (wr_data)
                  `BCH_CMD_ABORT:
                  begin
                     flg_next.op_done = 1'b1;
                  end
                  `BCH_CMD_PURGE:
                  begin
                     prm_next.channel_select = '0;
                     prm_next.transfer_rate_cfg = '0;
                     prm_next.page_address_low = '0;
                     prm_next.page_address_high_unit = '0;
                     sel_next = '0;
                     fsa_seen_next = '0;
                     nfc_next = '0;
                     bl_idx_next = '0;
                     f_flush = 1'b1;
                     flg_next.op_done = 1'b1;
                  end
                  `BCH_CMD_INIT:
                  begin
                     flg_next.busy = 1'b1;
                     cnt_next = '0;
                     state_next = BCH_INIT;
                  end
                  `BCH_CMD_WR_BLREG, `BCH_CMD_WBL_MASKED:
                  begin
                     flg_next.busy = 1'b1;
                     bl_idx_next = '0;
                     state_next = BCH_WR_BL;
                  end
                  `BCH_CMD_RD_BLREG:
                  begin
                     flg_next.busy = 1'b1;
                     bl_idx_next = '0;
                     f_flush = 1'b1;
                     state_next = BCH_RD_BL;
                  end
                  `BCH_CMD_FIFO_RST, `BCH_CMD_SW_RST:
                  begin
                     f_flush = 1'b1;
                     flg_next.op_done = 1'b1;
                  end
                  default:
                  begin
                     // Bubble transfers live beyond this port
                     flg_next.op_done = 1'b1;
                  end
               endcase
            end
         end
         BCH_INIT:
         begin
            // A present formatter answers the probe; otherwise time out
            cnt_next = cnt_reg + 1'b1;
            if (formatter_sense_amp_ready)
            begin
               flg_next.busy = 1'b0;
               flg_next.op_done = 1'b1;
               fsa_seen_next = prm_reg.channel_select[`BCH_CHAN_TWO_BIT] ? 2'h2 : 2'h1;
               state_next = BCH_IDLE;
            end
            else if (cnt_reg == `BCH_INIT_TMO_CYC)
            begin
               flg_next.busy = 1'b0;
               flg_next.op_fail = 1'b1;
               flg_next.timing_err = 1'b1;
               nfc_next = 2'h3;
               state_next = BCH_IDLE;
            end
         end
         BCH_WR_BL:
         begin
            // Bootloop mover drains the FIFO into the register
            if (f_out_valid)
            begin
               f_out_ready = 1'b1;
               bl_idx_next = bl_idx_reg + 1'b1;
            end
            if ((f_out_valid && bl_idx_reg == `BCH_BL_AW'(`BCH_BL_BYTES - 1))
                || !f_out_valid)
            begin
               flg_next.busy = 1'b0;
               flg_next.op_done = 1'b1;
               state_next = BCH_IDLE;
            end
         end
         BCH_RD_BL:
         begin
            f_in_valid = 1'b1;
            f_in_data = bl_mem[bl_idx_reg];
            if (f_in_ready)
            begin
               bl_idx_next = bl_idx_reg + 1'b1;
               if (bl_idx_reg == `BCH_BL_AW'(`BCH_BL_BYTES - 1))
               begin
                  flg_next.busy = 1'b0;
                  flg_next.op_done = 1'b1;
                  state_next = BCH_IDLE;
               end
            end
         end
         default:
         begin
            state_next = BCH_PWRUP;
         end
      endcase

      // Parity hint is sticky; a new event wins over a command clear
      if (formatter_sense_amp_parity_err)
      begin
         flg_next.parity_err = 1'b1;
      end

      // Status or FIFO data byte for the next read
      rd_data_next = '0;
      if (port_select_line)
      begin
         rd_data_next[`BCH_ST_BUSY] = flg_reg.busy;
         rd_data_next[`BCH_ST_OPDONE] = flg_reg.op_done;
         rd_data_next[`BCH_ST_OPFAIL] = flg_reg.op_fail;
         rd_data_next[`BCH_ST_TIMING] = flg_reg.timing_err;
         rd_data_next[`BCH_ST_PARITY] = flg_reg.parity_err;
         rd_data_next[`BCH_ST_DATA] = f_out_valid;
      end
      else
      begin
         rd_data_next = f_out_valid ? f_out_data : 8'h00;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= BCH_PWRUP;
         prm_reg <= '0;
         flg_reg <= '0;
         sel_reg <= '0;
         cnt_reg <= '0;
         bl_idx_reg <= '0;
         fsa_seen_reg <= '0;
         nfc_reg <= '0;
         discard_reg <= 1'b0;
         rd_data_reg <= 8'h00;
      end
      else
      begin
         state_reg <= state_next;
         prm_reg <= prm_next;
         flg_reg <= flg_next;
         sel_reg <= sel_next;
         cnt_reg <= cnt_next;
         bl_idx_reg <= bl_idx_next;
         fsa_seen_reg <= fsa_seen_next;
         nfc_reg <= nfc_next;
         discard_reg <= discard_next;
         if (cs && rd_stb)
         begin
            rd_data_reg <= rd_data_next;
         end
      end
   end

   // Bootloop register storage, no reset needed
   always_ff @(posedge clk)
   begin
      if (state_reg == BCH_WR_BL && f_out_valid)
      begin
         bl_mem[bl_idx_reg] <= f_out_data;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign rd_data = rd_data_reg;
   assign pwrup_done = (state_reg != BCH_PWRUP);
   assign one_page_mode = (prm_reg.block_length == `BCH_BLEN_ONE_PAGE);
   assign two_channel_mode = prm_reg.channel_select[`BCH_CHAN_TWO_BIT];
   assign std_rate_mode = (prm_reg.transfer_rate_cfg == `BCH_RATE_STD);
   assign page_address = {prm_reg.page_address_high_unit[3:0],
                          prm_reg.page_address_low};
   assign module_unit = prm_reg.page_address_high_unit[7:4];
endmodule : bch_host_port
`default_nettype wire

// File: dv/bch_host_port_props.sv
// Checker for the bubble controller host port
`default_nettype none
module bch_host_port_props
   import bch_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Host bus
   input wire logic cs,
   input wire logic rd_stb,
   input wire logic wr_stb,
   input wire logic port_select_line,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   // Formatter and decode
   input wire logic formatter_sense_amp_ready,
   input wire logic formatter_sense_amp_parity_err,
   input wire logic pwrup_done,
   input wire logic one_page_mode,
   input wire logic two_channel_mode,
   input wire logic std_rate_mode,
   input wire logic [11:0] page_address,
   input wire logic [3:0] module_unit
);
   // ------------------------------
   // Age since reset, saturating
   // ------------------------------
   logic [8:0] age_reg;
   logic [8:0] age_next;
   logic rd_cmd;
   assign rd_cmd = cs && rd_stb;
   always_comb
   begin
      age_next = (age_reg == 9'h1ff) ? age_reg : age_reg + 9'h001;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         age_reg <= 9'h000;
      else
         age_reg <= age_next;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_rd_hold;
      !rd_cmd && !$past(rd_cmd) |-> $stable(rd_data);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_pw_keep;
      !$fell(pwrup_done);
   endproperty
   a_pw_keep: assert property (p_pw_keep) else $error("power-up done fell");
   property p_pw_early;
      age_reg < 9'h0fa |-> !pwrup_done;
   endproperty
   a_pw_early: assert property (p_pw_early) else $error("power-up too short");
   property p_pw_late;
      age_reg == 9'h12c |-> pwrup_done;
   endproperty
   a_pw_late: assert property (p_pw_late) else $error("power-up too long");
   property p_pre_st;
      rd_cmd && port_select_line && !pwrup_done |=> rd_data == 8'h00;
   endproperty
   a_pre_st: assert property (p_pre_st) else $error("status before power-up");
   property p_st_gap;
      rd_cmd && port_select_line |=> !rd_data[3];
   endproperty
   a_st_gap: assert property (p_st_gap) else $error("unused status bit set");
   property p_par;
      pwrup_done && formatter_sense_amp_parity_err ##1 rd_cmd && port_select_line
         |=> rd_data[2];
   endproperty
   a_par: assert property (p_par) else $error("parity flag missing");
   property p_cfg_quiet;
      !pwrup_done |=> $stable({one_page_mode, two_channel_mode, std_rate_mode,
         page_address, module_unit});
   endproperty
   a_cfg_quiet: assert property (p_cfg_quiet) else $error("config moved early");
endmodule : bch_host_port_props
bind bch_host_port bch_host_port_props chk (.clk(clk), .rst_n(rst_n), .cs(cs),
   .rd_stb(rd_stb), .wr_stb(wr_stb), .port_select_line(port_select_line),
   .wr_data(wr_data), .rd_data(rd_data),
   .formatter_sense_amp_ready(formatter_sense_amp_ready),
   .formatter_sense_amp_parity_err(formatter_sense_amp_parity_err),
   .pwrup_done(pwrup_done), .one_page_mode(one_page_mode),
   .two_channel_mode(two_channel_mode), .std_rate_mode(std_rate_mode),
   .page_address(page_address), .module_unit(module_unit));
`default_nettype wire

// File: dv/bch_host_model.sv
// Host CPU bus model for the command/status and data ports
`default_nettype none
module bch_host_model
(
   // Clock
   input wire logic clk,
   // Host bus
   output logic cs,
   output logic rd_stb,
   output logic wr_stb,
   output logic port_select_line,
   output logic [7:0] wr_data,
   input wire logic [7:0] rd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      cs = 1'b0;
      rd_stb = 1'b0;
      wr_stb = 1'b0;
      port_select_line = 1'b0;
      wr_data = 8'h5a;
   end
   // ------------------------------
   // One access: pulse, then sample
   // ------------------------------
   // Released data lines flip so a stale byte never looks valid
   task automatic xfer(input logic psl, input logic wr, input logic [7:0] d,
      output logic [7:0] q);
      @(negedge clk);
      cs = 1'b1;
      port_select_line = psl;
      wr_data = wr ? d : ~wr_data;
      wr_stb = wr;
      rd_stb = !wr;
      @(negedge clk);
      cs = 1'b0;
      rd_stb = 1'b0;
      wr_stb = 1'b0;
      wr_data = ~wr_data;
      @(negedge clk);
      q = rd_data;
   endtask : xfer
endmodule : bch_host_model
`default_nettype wire

// File: dv/bch_host_port_test.sv
// Self-checking testbench for the bubble controller host port
`default_nettype none
module bch_host_port_test
   import bch_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, cs, rd_stb, wr_stb, psl, fsa_rdy, fsa_par, pwrup_done;
   logic one_page_mode, two_channel_mode, std_rate_mode;
   logic [7:0] wr_data, rd_data, q;
   logic [11:0] page_address;
   logic [3:0] module_unit;
   logic [15:0] modes, addr;
   int n_fail = 0;
   int cmp_count = 0;
   int cyc = 0;
   assign modes = {13'h0, one_page_mode, two_channel_mode, std_rate_mode};
   assign addr = {page_address, module_unit};
   bch_host_port uut (.clk(clk), .rst_n(rst_n), .cs(cs), .rd_stb(rd_stb),
      .wr_stb(wr_stb), .port_select_line(psl), .wr_data(wr_data), .rd_data(rd_data),
      .formatter_sense_amp_ready(fsa_rdy), .formatter_sense_amp_parity_err(fsa_par),
      .pwrup_done(pwrup_done), .one_page_mode(one_page_mode),
      .two_channel_mode(two_channel_mode), .std_rate_mode(std_rate_mode),
      .page_address(page_address), .module_unit(module_unit));
   bch_host_model host (.clk(clk), .cs(cs), .rd_stb(rd_stb), .wr_stb(wr_stb),
      .port_select_line(psl), .wr_data(wr_data), .rd_data(rd_data));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ------------------------------
   // Access and check tasks
   // ------------------------------
   task automatic cmd(input logic [7:0] c);
      logic [7:0] x;
      host.xfer(1'b1, 1'b1, c, x);
   endtask : cmd
   task automatic wdat(input logic [7:0] d);
      logic [7:0] x;
      host.xfer(1'b0, 1'b1, d, x);
   endtask : wdat
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic stat();
      host.xfer(1'b1, 1'b0, 8'h00, q);
   endtask : stat
   // Busy polling is bounded so a stuck command cannot hang the run
   task automatic wait_idle();
      int k;
      k = 0;
      stat();
      while (q[7] !== 1'b0 && k < 600)
      begin
         stat();
         k++;
      end
      chk({15'h0, q[7]}, 16'h0000);
   endtask : wait_idle
   task automatic load(input logic [7:0] b, c, d, e, f);
      cmd(8'h0b);
      wdat(b);
      wdat(c);
      wdat(d);
      wdat(e);
      wdat(f);
   endtask : load
   task automatic fill(input logic [7:0] base, input int n);
      for (int i = 0; i < n; i++)
         wdat(base + 8'(i));
   endtask : fill
   task automatic drain(input logic [7:0] base, input int n);
      for (int i = 0; i < n; i++)
      begin
         host.xfer(1'b0, 1'b0, 8'h00, q);
         chk({8'h0, q}, {8'h0, base + 8'(i)});
      end
   endtask : drain
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         results();
      end
   end
   // ------------------------------
   // Test sequence
   // ------------------------------
   initial
   begin
      rst_n = 1'b0;
      fsa_rdy = 1'b1;
      fsa_par = 1'b0;
      repeat (10) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      stat();
      chk({8'h0, q}, 16'h0000);
      repeat (300) @(negedge clk);
      load(8'h01, 8'h10, 8'h08, 8'h00, 8'h00);
      chk(modes, 16'h0007);
      chk(addr, 16'h0000);
      stat();
      chk({8'h0, q}, 16'h0040);
      cmd(8'h1e);
      wait_idle();
      chk(modes, 16'h0007);
      $display("test power-up and parameters done");
      fill(8'h05, 40);
      wdat(8'hee);
      stat();
      chk({8'h0, q & 8'hfb}, 16'h0041);
      drain(8'h05, 40);
      stat();
      chk({8'h0, q & 8'hfd}, 16'h0040);
      $display("test fifo buffer done");
      load(8'h01, 8'h10, 8'h00, 8'h34, 8'h52);
      chk(modes, 16'h0006);
      cmd(8'h19);
      wait_idle();
      chk({8'h0, q}, 16'h0040);
      cmd(8'h1e);
      wait_idle();
      chk({8'h0, q & 8'hfb}, 16'h0040);
      chk(modes, 16'h0004);
      chk(addr, 16'h0000);
      $display("test abort and purge done");
      fill(8'ha0, 6);
      load(8'h01, 8'h10, 8'h08, 8'h00, 8'h00);
      drain(8'ha1, 5);
      stat();
      chk({8'h0, q & 8'hfd}, 16'h0040);
      cmd(8'h1d);
      wait_idle();
      fill(8'h80, 40);
      cmd(8'h16);
      wait_idle();
      chk({8'h0, q & 8'hfb}, 16'h0040);
      cmd(8'h15);
      wait_idle();
      chk({8'h0, q & 8'hfb}, 16'h0041);
      drain(8'h80, 40);
      $display("test bootloop register done");
      // Parity stands into the status read so the checker sees the pair
      @(negedge clk);
      fsa_par = 1'b1;
      stat();
      fsa_par = 1'b0;
      chk({8'h0, q & 8'h04}, 16'h0004);
      fill(8'h30, 3);
      cmd(8'h1f);
      wait_idle();
      chk({8'h0, q & 8'h05}, 16'h0000);
      chk(modes, 16'h0007);
      $display("test software reset done");
      fsa_rdy = 1'b0;
      cmd(8'h11);
      wait_idle();
      chk({8'h0, q & 8'h10}, 16'h0010);
      $display("test initialize without formatter done");
      results();
   end
endmodule : bch_host_port_test
`default_nettype wire
